// [hdl/gmac_pkg.sv]
// Purpose: constants and types shared by the gauge mode and alert control block
// Assumes: 50 MHz clock, 16-bit register data on a byte address
// Notes: the target address is held for the serial bus front end
package gmac_pkg;

	// timing
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned FIRST_CONV_MS = 250;
	localparam int unsigned CONV_PERIOD_MS = 1000;
	localparam int unsigned FIRST_CONV_CYC = (CLK_HZ / 1000) * FIRST_CONV_MS;
	localparam int unsigned CONV_PERIOD_CYC = (CLK_HZ / 1000) * CONV_PERIOD_MS;
	localparam int CNT_W = 32;

	// serial bus target address
	localparam logic [6:0] BUS_TARGET_ADDR = 7'h55;

	// register offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_CURRENT = 8'h04;
	localparam logic [7:0] OFS_TEMPERATURE = 8'h06;
	localparam logic [7:0] OFS_VOLTAGE = 8'h08;
	localparam logic [7:0] OFS_ALERT_FLAG = 8'h0a;
	localparam logic [7:0] OFS_CHARGE_LEVEL = 8'h2c;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h36;
	localparam logic [7:0] OFS_DESIGN_CAP = 8'h3c;
	localparam logic [7:0] OFS_ALERT_ENABLE = 8'h70;
	localparam logic [7:0] OFS_MODE_CONFIG = 8'h72;
	localparam logic [7:0] OFS_VOLT_HIGH = 8'h74;
	localparam logic [7:0] OFS_VOLT_LOW = 8'h76;
	localparam logic [7:0] OFS_TEMP_HIGH = 8'h78;
	localparam logic [7:0] OFS_CURR_LIMIT = 8'h7a;
	localparam logic [7:0] OFS_LEVEL_LOW = 8'h7c;

	// reset values
	localparam logic [15:0] RST_CURRENT = 16'h0000;
	localparam logic [15:0] RST_TEMPERATURE = 16'h0ba6;
	localparam logic [15:0] RST_VOLTAGE = 16'h0ed8;
	localparam logic [15:0] RST_CHARGE_LEVEL = 16'h0032;
	localparam logic [15:0] RST_DESIGN_CAP = 16'h07d0;
	localparam logic [15:0] RST_MODE_CONFIG = 16'h0040;

	// control commands
	localparam logic [15:0] CMD_QUICK_SENSE = 16'h4000;
	localparam logic [15:0] CMD_SLEEP_ENTER = 16'h0001;
	localparam logic [15:0] CMD_SLEEP_EXIT = 16'h0002;
	localparam logic [15:0] CMD_SHDN_ENTER = 16'h0003;
	localparam logic [15:0] CMD_SHDN_EXIT = 16'h0004;

	// mode config fields
	localparam int CFG_SLEEP_EN_BIT = 0;
	localparam int CFG_SHDN_EN_BIT = 1;
	localparam int CFG_IRQ_EN_BIT = 2;
	localparam int CFG_MULT_LSB = 4;
	localparam int CFG_MULT_W = 5;
	localparam logic [4:0] SLEEP_MULT_MIN = 5'h02;
	localparam logic [4:0] SLEEP_MULT_MAX = 5'h10;

	// measurement span
	localparam logic [15:0] VOLT_MIN_MV = 16'h09c4;
	localparam logic [15:0] VOLT_MAX_MV = 16'h157c;
	localparam logic signed [15:0] CURR_MAX_MA = 16'sh2710;

	// alert bit positions
	localparam int ALERT_N = 9;
	localparam int AL_CHARGE_OVERTEMP = 0;
	localparam int AL_DISCHARGE_OVERTEMP = 1;
	localparam int AL_VOLTAGE_HIGH = 2;
	localparam int AL_VOLTAGE_LOW = 3;
	localparam int AL_CHARGE_LEVEL_LOW = 4;
	localparam int AL_CHARGE_LEVEL_CHANGED = 5;
	localparam int AL_CHARGE_OVERCURRENT = 6;
	localparam int AL_DISCHARGE_OVERCURRENT = 7;
	localparam int AL_TEMPERATURE_CHANGED = 8;
	localparam logic [8:0] AL_CHANGE_MASK = 9'h120;

	typedef enum logic [1:0] {
		MODE_ACTIVE,
		MODE_SLEEP,
		MODE_SHDN_CMD,
		MODE_SHDN_BUS
	} gmac_mode_e;

endpackage : gmac_pkg

// [hdl/gmac_top.sv]
// Purpose: measurement scheduler, power modes, quick sense and alert logic of a gauge
// Assumes: all inputs synchronous to clk; front end delivers sampled codes
// Notes: alarm pin is open drain, driven low while its enable is high
//
// Overview of operation
// R1 - first conversion 250ms, then every 1s
// R2 - fresh voltage 1s after leaving sleep
// R3 - voltage in mV, span 2.5 to 5.5V
// R4 - signed current in mA, 10A span
// R5 - design capacity 1mAh steps, resets 0x07D0
// R6 - charge level read-only, first at 250ms
// R7 - three power modes, active after reset
// R8 - active mode refreshes measurements every second
// R9 - sleep period 2 to 16 times, default 4
// R10 - sleep entry and exit only when enabled
// R11 - shutdown halts measurement and register updates
// R12 - shutdown entry by command or bus low
// R13 - shutdown exit matches its entry path
// R14 - command 0x4000 restarts sensing and charge level
// R15 - nine alert conditions detected
// R16 - host arms alerts before use
// R17 - disabled alert flag untouched; enabled sets
// R18 - ordinary flags clear when condition ends
// R19 - flag change with irq enabled raises alarm
// R20 - only irq register read clears alarm
// R21 - clearing irq enable keeps pending alarm
// R22 - disabling an alert clears its flag
// R23 - serial target address 7'b1010101, fast mode
// R24 - alerts evaluated once per measurement period
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
module gmac_top #(
	parameter int unsigned FIRST_CYC = gmac_pkg::FIRST_CONV_CYC,
	parameter int unsigned PERIOD_CYC = gmac_pkg::CONV_PERIOD_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// measurement front end
	input wire logic [15:0] adc_voltage_mv,
	input wire logic signed [15:0] adc_current_ma,
	input wire logic [15:0] adc_temperature,
	input wire logic [15:0] est_charge_level,
	input wire logic sleep_detect,
	input wire logic wake_detect,
	output logic conv_start,
	output logic soc_restart,
	output logic [1:0] power_mode,
	// serial bus line levels
	input wire logic scl_in,
	input wire logic sda_in,
	// alarm pin
	output logic alarm_out,
	output logic alarm_oe
);
	import gmac_pkg::*;
	localparam logic [6:0] TARGET_ADDR = BUS_TARGET_ADDR; // R23

	// alert conditions from one set of samples
	function automatic logic [ALERT_N-1:0] alert_cond(
		input logic [15:0] v,
		input logic signed [15:0] i,
		input logic [15:0] t,
		input logic [15:0] soc,
		input logic [15:0] t_prev,
		input logic [15:0] soc_prev,
		input logic [15:0] vh,
		input logic [15:0] vl,
		input logic [15:0] th,
		input logic [15:0] il,
		input logic [15:0] sl
	);
		logic [ALERT_N-1:0] c;
		logic [15:0] mag;
		c = '0;
		mag = (i < 0) ? 16'(-i) : 16'(i);
		c[AL_CHARGE_OVERTEMP] = (i > 0) && (t > th);
		c[AL_DISCHARGE_OVERTEMP] = (i < 0) && (t > th);
		c[AL_VOLTAGE_HIGH] = v > vh;
		c[AL_VOLTAGE_LOW] = v < vl;
		c[AL_CHARGE_LEVEL_LOW] = soc < sl;
		c[AL_CHARGE_LEVEL_CHANGED] = soc != soc_prev;
		c[AL_CHARGE_OVERCURRENT] = (i > 0) && (mag > il);
		c[AL_DISCHARGE_OVERCURRENT] = (i < 0) && (mag > il);
		c[AL_TEMPERATURE_CHANGED] = t != t_prev;
		return c;
	endfunction : alert_cond

	// mode and scheduler state
	gmac_mode_e mode_q, mode_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [4:0] sub_q, sub_d;
	logic conv_start_q, conv_start_d;
	logic soc_restart_q, soc_restart_d;

	// measurement registers
	logic [15:0] voltage_q, voltage_d;
	logic [15:0] current_q, current_d;
	logic [15:0] temperature_q, temperature_d;
	logic [15:0] charge_level_q, charge_level_d;
	logic [15:0] design_cap_q, design_cap_d;

	// configuration registers
	logic [15:0] mode_config_q, mode_config_d;
	logic [ALERT_N-1:0] alert_en_q, alert_en_d;
	logic [15:0] volt_high_q, volt_high_d;
	logic [15:0] volt_low_q, volt_low_d;
	logic [15:0] temp_high_q, temp_high_d;
	logic [15:0] curr_limit_q, curr_limit_d;
	logic [15:0] level_low_q, level_low_d;

	// alert state
	logic [ALERT_N-1:0] flag_q, flag_d;
	logic [ALERT_N-1:0] irq_q, irq_d;
	logic alarm_oe_q, alarm_oe_d;
	logic [15:0] rdata_q, rdata_d;

	// decoded helpers
	logic sleep_en, shdn_en, irq_en, sample, in_shdn;
	logic [4:0] mult;
	logic [ALERT_N-1:0] armed, cond;
	logic [15:0] v_clamp, i_clamp;
	logic signed [15:0] i_s;

	always_comb begin
		sleep_en = mode_config_q[CFG_SLEEP_EN_BIT];
		shdn_en = mode_config_q[CFG_SHDN_EN_BIT];
		irq_en = mode_config_q[CFG_IRQ_EN_BIT];
		mult = mode_config_q[CFG_MULT_LSB +: CFG_MULT_W];
		if (mult < SLEEP_MULT_MIN) begin
			mult = SLEEP_MULT_MIN; // R9
		end else if (mult > SLEEP_MULT_MAX) begin
			mult = SLEEP_MULT_MAX; // R9
		end
		in_shdn = (mode_q == MODE_SHDN_CMD) || (mode_q == MODE_SHDN_BUS);

		// clamp to measurement span
		v_clamp = adc_voltage_mv; // R3
		if (v_clamp < VOLT_MIN_MV) begin
			v_clamp = VOLT_MIN_MV; // R3
		end else if (v_clamp > VOLT_MAX_MV) begin
			v_clamp = VOLT_MAX_MV; // R3
		end
		i_s = adc_current_ma;
		if (i_s > CURR_MAX_MA) begin
			i_s = CURR_MAX_MA; // R4
		end else if (i_s < -CURR_MAX_MA) begin
			i_s = -CURR_MAX_MA; // R4
		end
		i_clamp = 16'(i_s);

		// threshold alerts armed by bit or by a nonzero threshold
		armed = alert_en_q;
		armed[AL_CHARGE_OVERTEMP] = alert_en_q[AL_CHARGE_OVERTEMP] || (temp_high_q != '0);
		armed[AL_DISCHARGE_OVERTEMP] = alert_en_q[AL_DISCHARGE_OVERTEMP] || (temp_high_q != '0);
		armed[AL_VOLTAGE_HIGH] = alert_en_q[AL_VOLTAGE_HIGH] || (volt_high_q != '0);
		armed[AL_VOLTAGE_LOW] = alert_en_q[AL_VOLTAGE_LOW] || (volt_low_q != '0);
		armed[AL_CHARGE_LEVEL_LOW] = alert_en_q[AL_CHARGE_LEVEL_LOW] || (level_low_q != '0);
		armed[AL_CHARGE_OVERCURRENT] = alert_en_q[AL_CHARGE_OVERCURRENT] || (curr_limit_q != '0);
		armed[AL_DISCHARGE_OVERCURRENT] = alert_en_q[AL_DISCHARGE_OVERCURRENT] || (curr_limit_q != '0);

		cond = alert_cond(v_clamp, i_s, adc_temperature, est_charge_level, temperature_q,
			charge_level_q, volt_high_q, volt_low_q, temp_high_q, curr_limit_q,
			level_low_q); // R15

		// defaults
		mode_d = mode_q;
		cnt_d = cnt_q;
		sub_d = sub_q;
		soc_restart_d = 1'b0;
		voltage_d = voltage_q;
		current_d = current_q;
		temperature_d = temperature_q;
		charge_level_d = charge_level_q;
		design_cap_d = design_cap_q;
		mode_config_d = mode_config_q;
		alert_en_d = alert_en_q;
		volt_high_d = volt_high_q;
		volt_low_d = volt_low_q;
		temp_high_d = temp_high_q;
		curr_limit_d = curr_limit_q;
		level_low_d = level_low_q;
		flag_d = flag_q;
		irq_d = irq_q;
		sample = 1'b0;

		// measurement scheduler, halted in shutdown
		if (!in_shdn) begin // R11
			if (cnt_q == '0) begin
				cnt_d = CNT_W'(PERIOD_CYC - 1); // R1
				if (mode_q == MODE_SLEEP) begin
					if (sub_q >= mult - 5'h01) begin
						sub_d = '0;
						sample = 1'b1; // R9
					end else begin
						sub_d = sub_q + 5'h01;
					end
				end else begin
					sample = 1'b1; // R8
				end
			end else begin
				cnt_d = cnt_q - 1'b1;
			end
		end
		conv_start_d = sample; // R9

		// store results at the end of each period
		if (sample) begin
			voltage_d = v_clamp; // R1
			current_d = i_clamp; // R4
			temperature_d = adc_temperature; // R8
			charge_level_d = est_charge_level; // R6
		end

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				OFS_DESIGN_CAP: design_cap_d = reg_wdata; // R5
				OFS_MODE_CONFIG: mode_config_d = reg_wdata;
				OFS_ALERT_ENABLE: alert_en_d = reg_wdata[ALERT_N-1:0];
				OFS_VOLT_HIGH: volt_high_d = reg_wdata;
				OFS_VOLT_LOW: volt_low_d = reg_wdata;
				OFS_TEMP_HIGH: temp_high_d = reg_wdata;
				OFS_CURR_LIMIT: curr_limit_d = reg_wdata;
				OFS_LEVEL_LOW: level_low_d = reg_wdata;
				OFS_ALERT_FLAG: flag_d = flag_q & (reg_wdata[ALERT_N-1:0] | ~AL_CHANGE_MASK);
				default: begin
				end
			endcase
		end

		// control commands
		if (reg_wr && (reg_addr == OFS_CONTROL)) begin
			case (reg_wdata)
				CMD_QUICK_SENSE: begin
					if (!in_shdn) begin
						cnt_d = CNT_W'(FIRST_CYC - 1); // R14
						sub_d = '0;
						soc_restart_d = 1'b1; // R14
					end
				end
				CMD_SLEEP_ENTER: begin
					if (sleep_en && (mode_q == MODE_ACTIVE)) begin
						mode_d = MODE_SLEEP; // R10
					end
				end
				CMD_SLEEP_EXIT: begin
					if (sleep_en && (mode_q == MODE_SLEEP)) begin
						mode_d = MODE_ACTIVE; // R10
						cnt_d = CNT_W'(PERIOD_CYC - 1); // R2
						sub_d = '0;
					end
				end
				CMD_SHDN_ENTER: begin
					if (shdn_en && !in_shdn) begin
						mode_d = MODE_SHDN_CMD; // R12
					end
				end
				CMD_SHDN_EXIT: begin
					if (mode_q == MODE_SHDN_CMD) begin
						mode_d = MODE_ACTIVE; // R13
						cnt_d = CNT_W'(PERIOD_CYC - 1);
						sub_d = '0;
					end
				end
				default: begin
				end
			endcase
		end else begin
			case (mode_q)
				MODE_ACTIVE: begin
					if (shdn_en && !scl_in && !sda_in) begin
						mode_d = MODE_SHDN_BUS; // R12
					end else if (sleep_en && sleep_detect) begin
						mode_d = MODE_SLEEP; // R10
					end
				end
				MODE_SLEEP: begin
					if (shdn_en && !scl_in && !sda_in) begin
						mode_d = MODE_SHDN_BUS; // R12
					end else if (sleep_en && wake_detect) begin
						mode_d = MODE_ACTIVE; // R10
						cnt_d = CNT_W'(PERIOD_CYC - 1); // R2
						sub_d = '0;
					end
				end
				MODE_SHDN_BUS: begin
					if (scl_in && sda_in) begin
						mode_d = MODE_ACTIVE; // R13
						cnt_d = CNT_W'(PERIOD_CYC - 1);
						sub_d = '0;
					end
				end
				MODE_SHDN_CMD: mode_d = MODE_SHDN_CMD;
				default: mode_d = MODE_ACTIVE;
			endcase
		end
		// irq read also clears the change flags
		if (reg_rd && (reg_addr == OFS_IRQ_STATUS)) begin
			flag_d = flag_d & ~AL_CHANGE_MASK;
			irq_d = '0; // R20
		end
		// alert evaluation at measurement boundaries, set wins over clear
		if (sample) begin // R24
			flag_d = ((flag_d & AL_CHANGE_MASK) | (cond & armed)) & (cond | AL_CHANGE_MASK); // R18
			flag_d = (flag_d & armed) | (flag_q & ~armed); // R17
		end
		flag_d = flag_d & alert_en_d | flag_d & armed & ~alert_en_q; // R22
		// irq on flag change only, never cleared by irq enable
		if (irq_en) begin
			irq_d = irq_d | (flag_d ^ flag_q); // R19
		end
		alarm_oe_d = |irq_d; // R21
		// read mux
		rdata_d = '0;
		if (reg_rd) begin
			case (reg_addr)
				OFS_CONTROL: rdata_d = {14'h0000, mode_q};
				OFS_CURRENT: rdata_d = current_q;
				OFS_TEMPERATURE: rdata_d = temperature_q;
				OFS_VOLTAGE: rdata_d = voltage_q;
				OFS_ALERT_FLAG: rdata_d = {7'h00, flag_q};
				OFS_CHARGE_LEVEL: rdata_d = charge_level_q; // R6
				OFS_IRQ_STATUS: rdata_d = {7'h00, irq_q};
				OFS_DESIGN_CAP: rdata_d = design_cap_q; // R5
				OFS_ALERT_ENABLE: rdata_d = {7'h00, alert_en_q};
				OFS_MODE_CONFIG: rdata_d = mode_config_q;
				OFS_VOLT_HIGH: rdata_d = volt_high_q;
				OFS_VOLT_LOW: rdata_d = volt_low_q;
				OFS_TEMP_HIGH: rdata_d = temp_high_q;
				OFS_CURR_LIMIT: rdata_d = curr_limit_q;
				OFS_LEVEL_LOW: rdata_d = level_low_q;
				default: rdata_d = '0;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			mode_q <= MODE_ACTIVE; // R7
			cnt_q <= CNT_W'(FIRST_CYC - 1); // R1
			sub_q <= '0;
			conv_start_q <= 1'b0;
			soc_restart_q <= 1'b0;
			voltage_q <= RST_VOLTAGE;
			current_q <= RST_CURRENT;
			temperature_q <= RST_TEMPERATURE;
			charge_level_q <= RST_CHARGE_LEVEL;
			design_cap_q <= RST_DESIGN_CAP; // R5
			mode_config_q <= RST_MODE_CONFIG; // R9
			alert_en_q <= '0;
			volt_high_q <= '0;
			volt_low_q <= '0;
			temp_high_q <= '0;
			curr_limit_q <= '0;
			level_low_q <= '0;
			flag_q <= '0;
			irq_q <= '0;
			alarm_oe_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			mode_q <= mode_d;
			cnt_q <= cnt_d;
			sub_q <= sub_d;
			conv_start_q <= conv_start_d;
			soc_restart_q <= soc_restart_d;
			voltage_q <= voltage_d;
			current_q <= current_d;
			temperature_q <= temperature_d;
			charge_level_q <= charge_level_d;
			design_cap_q <= design_cap_d;
			mode_config_q <= mode_config_d;
			alert_en_q <= alert_en_d;
			volt_high_q <= volt_high_d;
			volt_low_q <= volt_low_d;
			temp_high_q <= temp_high_d;
			curr_limit_q <= curr_limit_d;
			level_low_q <= level_low_d;
			flag_q <= flag_d;
			irq_q <= irq_d;
			alarm_oe_q <= alarm_oe_d;
			rdata_q <= rdata_d;
		end
	end
	// outputs
	assign reg_rdata = rdata_q;
	assign conv_start = conv_start_q;
	assign soc_restart = soc_restart_q;
	assign power_mode = mode_q;
	assign alarm_out = 1'b0;
	assign alarm_oe = alarm_oe_q; // R20
endmodule : gmac_top
`default_nettype wire

// [bench/gmac_checker.sv]
// Purpose: port assertions for the gauge mode and alert block
// Assumes: one clock, srst synchronous active high
// Notes: enable bits tracked from config writes
`timescale 1ns/1ns
`default_nettype none
module gmac_checker
	import gmac_pkg::*;
#(
	parameter int unsigned FIRST_CYC = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	// status and pins
	input wire logic conv_start,
	input wire logic soc_restart,
	input wire logic [1:0] power_mode,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic alarm_oe
);
	logic [1:0] en_q;
	logic [31:0] age_q;
	logic seen_q;
	logic irq_rd;
	assign irq_rd = reg_rd && reg_addr == OFS_IRQ_STATUS;
	always_ff @(posedge clk) begin
		if (srst) begin
			en_q <= 2'b00;
			age_q <= 32'h0;
			seen_q <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == OFS_MODE_CONFIG) begin
				en_q <= reg_wdata[1:0];
			end
			age_q <= age_q + 32'h1;
			seen_q <= seen_q | conv_start;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	first_conv_a: assert property (conv_start && !seen_q |->
		age_q + 2 >= FIRST_CYC && age_q <= FIRST_CYC + 2) else $error("first sample off time");
	conv_gap_a: assert property (conv_start |=> !conv_start [*8])
		else $error("samples too close");
	mode_rst_a: assert property ($fell(srst) |-> power_mode == 2'b00 && !alarm_oe)
		else $error("not active after reset");
	shdn_quiet_a: assert property (
		power_mode[1] && $past(power_mode[1]) && $past(power_mode[1], 2) |-> !conv_start)
		else $error("sample in shutdown");
	quick_sense_a: assert property (
		reg_wr && reg_addr == OFS_CONTROL && reg_wdata == CMD_QUICK_SENSE && !power_mode[1]
		|-> ##[1:2] soc_restart) else $error("no restart pulse");
	alarm_clear_a: assert property (
		$fell(alarm_oe) |-> $past(irq_rd) || $past(irq_rd, 2) || $past(irq_rd, 3))
		else $error("alarm released without status read");
	shdn_enter_a: assert property ($rose(power_mode[1]) |-> $past(en_q[1]))
		else $error("shutdown while disabled");
	sleep_enter_a: assert property (
		$past(power_mode) == 2'b00 && power_mode == 2'b01 |-> $past(en_q[0]))
		else $error("sleep while disabled");
	cmd_exit_a: assert property (
		$past(power_mode) == 2'b10 && power_mode != 2'b10 |-> $past(reg_wr)
		&& $past(reg_addr) == OFS_CONTROL && $past(reg_wdata) == CMD_SHDN_EXIT)
		else $error("command shutdown left without exit");
	bus_exit_a: assert property (
		$past(power_mode) == 2'b11 && power_mode != 2'b11 |-> $past(scl_in) && $past(sda_in))
		else $error("bus shutdown left with bus low");
endmodule : gmac_checker
bind gmac_top gmac_checker #(.FIRST_CYC(FIRST_CYC)) i_chk (.clk(clk), .srst(srst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.conv_start(conv_start), .soc_restart(soc_restart), .power_mode(power_mode),
	.scl_in(scl_in), .sda_in(sda_in), .alarm_oe(alarm_oe));
`default_nettype wire

// [bench/gmac_bus_host.sv]
// Purpose: host side of the serial bus, line levels only
// Assumes: pulled-up lines idle high
// Notes: hold_low pulls both lines low
`timescale 1ns/1ns
`default_nettype none
module gmac_bus_host (
	// clock and command
	input wire logic clk,
	input wire logic hold_low,
	// bus lines
	output var logic scl,
	output var logic sda
);
	always @(posedge clk) begin
		scl <= !hold_low;
		sda <= !hold_low;
	end
endmodule : gmac_bus_host
`default_nettype wire

// [bench/testbench.sv]
// Purpose: self-checking bench for the gauge mode and alert block
// Assumes: shortened periods, first 20 and period 50 cycles
// Notes: reads checked from a queue by a monitor
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import gmac_pkg::*;
	localparam int FC = 20;
	localparam int PC = 50;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] v_mv = 16'h0fa0;
	logic signed [15:0] i_ma = 16'sh0000;
	logic [15:0] lvl = 16'h0032;
	logic sl_det = 1'b0;
	logic wk = 1'b0;
	logic [15:0] tmp = 16'h0ba6;
	logic hold_low = 1'b0;
	logic [15:0] reg_rdata;
	logic conv_start, soc_restart, alarm_out, alarm_oe, scl, sda, pend, sr_seen;
	logic [1:0] power_mode;
	logic [15:0] exp_q[$];
	int n_errors = 0;
	int checks = 0;
	int seed = 83;
	int cyc = 0;
	int n;
	int mults[2] = '{2, 16};
	always #10 clk = ~clk;
	gmac_top #(.FIRST_CYC(FC), .PERIOD_CYC(PC)) i_dut (.clk(clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .adc_voltage_mv(v_mv), .adc_current_ma(i_ma),
		.adc_temperature(tmp), .est_charge_level(lvl), .sleep_detect(sl_det),
		.wake_detect(wk), .conv_start(conv_start), .soc_restart(soc_restart),
		.power_mode(power_mode), .scl_in(scl), .sda_in(sda), .alarm_out(alarm_out),
		.alarm_oe(alarm_oe));
	gmac_bus_host i_host (.clk(clk), .hold_low(hold_low), .scl(scl), .sda(sda));
	task automatic results();
		if (n_errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic near(input int got, input int exp);
		checks++;
		if (got > exp + 2 || got < exp - 2) begin
			n_errors++;
			$display("[ERR] %0t cycles %0d exp %0d", $time, got, exp);
		end
	endtask : near
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : rd
	task automatic wait_conv(output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (conv_start !== 1'b1 && c < 2000);
		if (c >= 2000) begin
			n_errors++;
			results();
		end
	endtask : wait_conv
	always @(negedge clk) begin
		if (pend === 1'b1) chk(reg_rdata, exp_q.pop_front());
		pend = reg_rd;
		cyc = srst ? 0 : cyc + 1;
		if (soc_restart === 1'b1) sr_seen = 1'b1;
	end
	initial begin
		@(posedge clk);
		v_mv <= 16'(2500 + $unsigned($random(seed)) % 3001);
		i_ma <= 16'($random(seed) % 10000);
		repeat (19) @(posedge clk);
		srst <= 1'b0;
		rd(OFS_VOLTAGE, RST_VOLTAGE);
		rd(OFS_CHARGE_LEVEL, RST_CHARGE_LEVEL);
		rd(OFS_CONTROL, 16'h0000);
		rd(OFS_DESIGN_CAP, RST_DESIGN_CAP);
		rd(OFS_MODE_CONFIG, RST_MODE_CONFIG);
		rd(8'h02, 16'h0000);
		wait_conv(n);
		near(cyc, FC + 1);
		wait_conv(n);
		near(n, PC);
		rd(OFS_VOLTAGE, v_mv);
		rd(OFS_CURRENT, i_ma);
		rd(OFS_ALERT_FLAG, 16'h0000);
		wr(OFS_CHARGE_LEVEL, 16'h0011);
		rd(OFS_CHARGE_LEVEL, lvl);
		wr(OFS_DESIGN_CAP, 16'h0bb8);
		rd(OFS_DESIGN_CAP, 16'h0bb8);
		@(posedge clk);
		v_mv <= 16'h0fa0;
		wr(OFS_VOLT_HIGH, 16'h0bb8);
		wait_conv(n);
		rd(OFS_ALERT_FLAG, 16'h0004);
		wr(OFS_MODE_CONFIG, 16'h0044);
		repeat (3) @(negedge clk);
		chk(alarm_oe, 1'b0);
		@(posedge clk);
		v_mv <= 16'h0a28;
		wait_conv(n);
		rd(OFS_ALERT_FLAG, 16'h0000);
		repeat (3) @(negedge clk);
		chk({alarm_oe, alarm_out}, 2'b10);
		wr(OFS_MODE_CONFIG, 16'h0040);
		repeat (3) @(negedge clk);
		chk(alarm_oe, 1'b1);
		rd(OFS_IRQ_STATUS, 16'h0004);
		repeat (3) @(negedge clk);
		chk(alarm_oe, 1'b0);
		wr(OFS_ALERT_ENABLE, 16'h0020);
		@(posedge clk);
		lvl <= 16'h0040;
		wait_conv(n);
		rd(OFS_ALERT_FLAG, 16'h0020);
		wr(OFS_ALERT_ENABLE, 16'h0000);
		rd(OFS_ALERT_FLAG, 16'h0000);
		wr(OFS_TEMP_HIGH, 16'h0c00);
		@(posedge clk);
		tmp <= 16'h0c80;
		i_ma <= 16'sh0064;
		wait_conv(n);
		rd(OFS_ALERT_FLAG, 16'h0001);
		@(posedge clk);
		i_ma <= -16'sh0064;
		wait_conv(n);
		rd(OFS_ALERT_FLAG, 16'h0002);
		wr(OFS_TEMP_HIGH, 16'h0000);
		rd(OFS_ALERT_FLAG, 16'h0000);
		wr(OFS_CONTROL, CMD_SLEEP_ENTER);
		rd(OFS_CONTROL, 16'h0000);
		wr(OFS_MODE_CONFIG, 16'h0041);
		wr(OFS_CONTROL, CMD_SLEEP_ENTER);
		rd(OFS_CONTROL, 16'h0001);
		wait_conv(n);
		wait_conv(n);
		near(n, 4 * PC);
		foreach (mults[k]) begin
			wr(OFS_MODE_CONFIG, 16'(mults[k] * 16 + 1));
			wait_conv(n);
			wait_conv(n);
			near(n, mults[k] * PC);
		end
		wr(OFS_CONTROL, CMD_SLEEP_EXIT);
		wait_conv(n);
		near(n, PC + 1);
		@(posedge clk);
		sl_det <= 1'b1;
		repeat (3) @(posedge clk);
		sl_det <= 1'b0;
		rd(OFS_CONTROL, 16'h0001);
		wr(OFS_CONTROL, CMD_SLEEP_EXIT);
		rd(OFS_CONTROL, 16'h0000);
		@(posedge clk);
		sl_det <= 1'b1;
		@(posedge clk);
		sl_det <= 1'b0;
		wk <= 1'b1;
		@(negedge clk);
		chk(power_mode, 2'b01);
		@(posedge clk);
		wk <= 1'b0;
		rd(OFS_CONTROL, 16'h0000);
		wr(OFS_CONTROL, CMD_SHDN_ENTER);
		rd(OFS_CONTROL, 16'h0000);
		wr(OFS_MODE_CONFIG, 16'h0042);
		wr(OFS_CONTROL, CMD_SHDN_ENTER);
		rd(OFS_CONTROL, 16'h0002);
		@(posedge clk);
		v_mv <= 16'h1388;
		repeat (120) @(negedge clk) chk(conv_start, 1'b0);
		rd(OFS_VOLTAGE, 16'h0a28);
		wr(OFS_CONTROL, CMD_SHDN_EXIT);
		rd(OFS_CONTROL, 16'h0000);
		@(posedge clk);
		hold_low <= 1'b1;
		repeat (4) @(negedge clk);
		wr(OFS_CONTROL, CMD_SHDN_EXIT);
		rd(OFS_CONTROL, 16'h0003);
		@(posedge clk);
		hold_low <= 1'b0;
		repeat (4) @(negedge clk);
		rd(OFS_CONTROL, 16'h0000);
		wait_conv(n);
		sr_seen = 1'b0;
		wr(OFS_CONTROL, CMD_QUICK_SENSE);
		wait_conv(n);
		near(n, FC + 1);
		chk(sr_seen, 1'b1);
		chk(BUS_TARGET_ADDR, 7'b1010101);
		results();
	end
endmodule : testbench
`default_nettype wire
